// *** core/pmrs_sequencer.sv ***
`timescale 1ns/1ps
`include "pmrs_defs.svh"
// Function
// - all contexts not-ready enters light doze; cpu clock kept, no memory access
// - sleep makes issuing context not-ready; qualified interrupt makes target ready unless halted
// - master stop enters idle; cpu clock halts, master clock and oscillator run
// - entering idle turns ready contexts not-ready; halted stay halted
// - interrupt leaving idle restarts cpu clock and readies target
// - scheduler runs in doze and idle; only qualified interrupts wake
// - doze and idle keep master clock; peripherals follow clock mask
// - master deep-stop halts all clocks and oscillator, retaining state
// - in hard sleep the scheduler is halted; interrupts never wake
// - stop or deep-stop from contexts one to four acts as sleep
// - stop and deep-stop operand is written to master status register
// - in hard sleep protocol engines freeze and contexts keep state
// - pin reset with power-on flag set does major master initialisation
// - major reset: other contexts status 0x2700, base zero, control 0x1800
// - major reset fully resets protocol engines and masks all peripheral clocks
// - pin reset with flag clear is minor; other contexts untouched
// - after minor reset others held off until master goes not-ready
// - minor reset gives engines minimal reset, instruction counters kept
// - minor reset leaves peripheral clock mask unchanged
// - power-on and test-port reset are major, set power flag, clear watchdog
// - watchdog reset is major, sets watchdog flag, power flag unchanged
// - pin reset major or minor by flag; power flag kept, watchdog cleared
// - cause register: watchdog bit 1 read-only, power flag bit 0, reset 1
// - clock mask bits inverted: one is off; all off at power-on
module pmrs_sequencer (
   // clock and power-on reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // reset sources, one-cycle pulses
   input wire logic pin_reset_i,
   input wire logic test_reset_i,
   input wire logic wdog_reset_i,
   // instructions from the execution unit
   input wire logic instr_valid_i,
   input wire logic [2:0] instr_ctx_i,
   input wire logic sleep_instr_i,
   input wire logic stop_instr_i,
   input wire logic deep_halt_instr_i,
   input wire logic [15:0] instr_operand_i,
   // interrupts, already routed to a context
   input wire logic irq_valid_i,
   input wire logic [2:0] irq_ctx_i,
   input wire logic irq_qualified_i,
   // software writes by the master context
   input wire logic cause_wr_i,
   input wire logic cause_por_wdata_i,
   input wire logic ckmask_wr_i,
   input wire logic [13:0] ckmask_wdata_i,
   // clock gating
   output logic cpu_clk_en_o,
   output logic master_clk_en_o,
   output logic osc_en_o,
   output logic scheduler_en_o,
   output logic mem_access_en_o,
   output logic [13:0] periph_clk_en_o,
   // power mode
   output logic light_doze_mode_o,
   output logic idle_mode_o,
   output logic hard_sleep_o,
   // context state
   output logic [4:0] ctx_ready_o,
   output logic [4:0] ctx_halted_o,
   output logic others_holdoff_o,
   output logic [15:0] master_status_o,
   // initialisation commands, one-cycle pulses
   output logic init_master_o,
   output logic init_others_o,
   output logic engine_full_reset_o,
   output logic engine_min_reset_o,
   // status
   output logic [31:0] reset_cause_o,
   output logic [13:0] ckmask_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   pmrs_pkg::pmrs_state_t s_q, s_d;
   logic is_master;
   logic any_reset;
   logic major;
   logic [4:0] irq_onehot;
   logic [4:0] instr_onehot;

   // decode of context numbers
   assign is_master = (instr_ctx_i == `PMRS_MASTER);
   assign any_reset = pin_reset_i | test_reset_i | wdog_reset_i;
   assign major = test_reset_i | wdog_reset_i | (pin_reset_i & s_q.por_flag);
   assign irq_onehot = (irq_valid_i && irq_qualified_i && irq_ctx_i < `PMRS_NCTX) ?
                       5'(5'h01 << irq_ctx_i) : 5'h00;
   assign instr_onehot = (instr_valid_i && instr_ctx_i < `PMRS_NCTX) ?
                         5'(5'h01 << instr_ctx_i) : 5'h00;

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.init = pmrs_pkg::PMRS_INIT_NONE;
      if (any_reset) begin
         // master context restarts ready; exits every mode
         s_d.mode = pmrs_pkg::PMRS_RUN;
         s_d.ready[0] = 1'b1;
         s_d.halted[0] = 1'b0;
         s_d.master_sr = `PMRS_SR_INIT;
         s_d.wdog_flag = wdog_reset_i;
         if (test_reset_i) begin
            s_d.por_flag = 1'b1;
            s_d.wdog_flag = 1'b0;
         end
         if (major) begin
            s_d.init = pmrs_pkg::PMRS_INIT_MAJOR;
            s_d.ready[4:1] = 4'h0;
            s_d.halted[4:1] = 4'hF;
            s_d.ckmask = `PMRS_CKMASK_RST;
            s_d.holdoff = 1'b0;
         end else begin
            s_d.init = pmrs_pkg::PMRS_INIT_MINOR;
            s_d.holdoff = 1'b1;
         end
      end else begin
         // software writes to cause and mask
         if (cause_wr_i) begin
            s_d.por_flag = cause_por_wdata_i;
         end
         if (ckmask_wr_i) begin
            s_d.ckmask = ckmask_wdata_i & `PMRS_CKMASK_VALID;
         end
         case (s_q.mode)
            pmrs_pkg::PMRS_RUN, pmrs_pkg::PMRS_DOZE: begin
               if (instr_valid_i && (stop_instr_i || deep_halt_instr_i)) begin
                  s_d.master_sr = instr_operand_i;
               end
               if (instr_valid_i && is_master && deep_halt_instr_i) begin
                  s_d.mode = pmrs_pkg::PMRS_HARD;
               end else if (instr_valid_i && is_master && stop_instr_i) begin
                  s_d.mode = pmrs_pkg::PMRS_IDLE;
                  s_d.ready = 5'h00;
               end else begin
                  if (instr_valid_i && (sleep_instr_i || stop_instr_i || deep_halt_instr_i)) begin
                     s_d.ready = s_q.ready & ~instr_onehot;
                  end
                  s_d.ready = (s_d.ready | irq_onehot) & ~s_q.halted;
                  s_d.mode = (s_d.ready == 5'h00) ? pmrs_pkg::PMRS_DOZE :
                             pmrs_pkg::PMRS_RUN;
               end
            end
            pmrs_pkg::PMRS_IDLE: begin
               if ((irq_onehot & ~s_q.halted) != 5'h00) begin
                  s_d.ready = irq_onehot & ~s_q.halted;
                  s_d.mode = pmrs_pkg::PMRS_RUN;
               end
            end
            pmrs_pkg::PMRS_HARD: begin
               s_d.mode = pmrs_pkg::PMRS_HARD;
            end
            default: begin
               s_d.mode = pmrs_pkg::PMRS_RUN;
            end
         endcase
         // master going not-ready releases the others
         if (s_q.holdoff && !s_d.ready[0]) begin
            s_d.holdoff = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q.mode <= pmrs_pkg::PMRS_RUN;
         s_q.ready <= 5'h01;
         s_q.halted <= 5'h1E;
         s_q.por_flag <= 1'b1;
         s_q.wdog_flag <= 1'b0;
         s_q.ckmask <= `PMRS_CKMASK_RST;
         s_q.holdoff <= 1'b0;
         s_q.master_sr <= `PMRS_SR_INIT;
         s_q.init <= pmrs_pkg::PMRS_INIT_MAJOR;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign light_doze_mode_o = (s_q.mode == pmrs_pkg::PMRS_DOZE);
   assign idle_mode_o = (s_q.mode == pmrs_pkg::PMRS_IDLE);
   assign hard_sleep_o = (s_q.mode == pmrs_pkg::PMRS_HARD);
   assign cpu_clk_en_o = !idle_mode_o && !hard_sleep_o;
   assign master_clk_en_o = !hard_sleep_o;
   assign osc_en_o = !hard_sleep_o;
   assign scheduler_en_o = !hard_sleep_o;
   assign mem_access_en_o = (s_q.mode == pmrs_pkg::PMRS_RUN);
   assign periph_clk_en_o = hard_sleep_o ? 14'h0000 :
                            (~s_q.ckmask & `PMRS_CKMASK_VALID);
   assign ctx_ready_o = s_q.ready;
   assign ctx_halted_o = s_q.halted;
   assign others_holdoff_o = s_q.holdoff;
   assign master_status_o = s_q.master_sr;
   assign init_master_o = (s_q.init != pmrs_pkg::PMRS_INIT_NONE);
   assign init_others_o = (s_q.init == pmrs_pkg::PMRS_INIT_MAJOR);
   assign engine_full_reset_o = (s_q.init == pmrs_pkg::PMRS_INIT_MAJOR);
   assign engine_min_reset_o = (s_q.init == pmrs_pkg::PMRS_INIT_MINOR);
   assign reset_cause_o = {30'h0, s_q.wdog_flag, s_q.por_flag};
   assign ckmask_o = s_q.ckmask;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_doze_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_q.mode == pmrs_pkg::PMRS_RUN && s_d.ready == 5'h00 && !any_reset &&
       s_d.mode != pmrs_pkg::PMRS_HARD && s_d.mode != pmrs_pkg::PMRS_IDLE)
      |=> light_doze_mode_o && cpu_clk_en_o && !mem_access_en_o)
      else $error("doze not entered with all contexts asleep");
   chk_idle_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cpu_clk_en_o && instr_valid_i && is_master && stop_instr_i && !deep_halt_instr_i
       && !any_reset) |=> idle_mode_o && !cpu_clk_en_o && ctx_ready_o == 5'h00
       && ctx_halted_o == $past(s_q.halted))
      else $error("idle entry wrong");
   chk_idle_wake: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (idle_mode_o && !any_reset && (irq_onehot & ~s_q.halted) != 5'h00)
      |=> cpu_clk_en_o && (ctx_ready_o & $past(irq_onehot)) != 5'h00)
      else $error("idle not left on interrupt");
   chk_unqual_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (idle_mode_o && !any_reset && !irq_qualified_i) |=> idle_mode_o)
      else $error("unqualified interrupt woke idle");
   chk_hard_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (hard_sleep_o && !any_reset) |=> hard_sleep_o && !scheduler_en_o && !osc_en_o
      && periph_clk_en_o == 14'h0000 && $stable(ctx_ready_o))
      else $error("hard sleep left without reset");
   chk_sub_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cpu_clk_en_o && instr_valid_i && !is_master && (stop_instr_i || deep_halt_instr_i)
       && !any_reset) |=> !idle_mode_o && !hard_sleep_o)
      else $error("subordinate stop changed mode");
   chk_operand: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cpu_clk_en_o && instr_valid_i && (stop_instr_i || deep_halt_instr_i) && !any_reset)
      |=> master_status_o == $past(instr_operand_i))
      else $error("operand not stored");
   chk_major_init: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (pin_reset_i && s_q.por_flag && !cause_wr_i)
      |=> engine_full_reset_o && ckmask_o == `PMRS_CKMASK_RST && ctx_halted_o == 5'h1E
      ##1 (!engine_full_reset_o || $past(any_reset)))
      else $error("major init wrong");
   chk_minor_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (pin_reset_i && !s_q.por_flag && !test_reset_i && !wdog_reset_i)
      |=> engine_min_reset_o && $stable(ckmask_o) && ctx_ready_o[0] && others_holdoff_o
      && reset_cause_o == 32'h0000_0000)
      else $error("minor reset disturbed state");
   chk_wdog_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wdog_reset_i && !test_reset_i) |=> reset_cause_o[`PMRS_CAUSE_WDOG_BIT]
      && reset_cause_o[`PMRS_CAUSE_POR_BIT] == $past(s_q.por_flag))
      else $error("watchdog flag wrong");
   chk_master_init: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      any_reset |=> init_master_o && ctx_ready_o[0] && !ctx_halted_o[0]
      && master_status_o == `PMRS_SR_INIT)
      else $error("master context not initialised");
   chk_sleep_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cpu_clk_en_o && instr_valid_i && sleep_instr_i && !stop_instr_i && !deep_halt_instr_i
       && !any_reset && (irq_onehot & instr_onehot) == 5'h00)
      |=> (ctx_ready_o & $past(instr_onehot)) == 5'h00)
      else $error("sleeping context still ready");
   chk_doze_clocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (light_doze_mode_o || idle_mode_o) |-> master_clk_en_o && scheduler_en_o && osc_en_o
      && periph_clk_en_o == (~ckmask_o & `PMRS_CKMASK_VALID))
      else $error("clocks wrong in doze or idle");
   chk_hard_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cpu_clk_en_o && instr_valid_i && is_master && deep_halt_instr_i && !any_reset)
      |=> hard_sleep_o && !master_clk_en_o && !osc_en_o && ctx_ready_o == $past(ctx_ready_o))
      else $error("hard sleep entry wrong");
   chk_holdoff_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      others_holdoff_o |-> ctx_ready_o[0])
      else $error("holdoff kept after master went not-ready");
   chk_minor_others: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (pin_reset_i && !s_q.por_flag && !test_reset_i && !wdog_reset_i)
      |=> !engine_full_reset_o && !init_others_o && ctx_halted_o == $past(ctx_halted_o))
      else $error("minor reset touched other contexts");
   chk_test_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      test_reset_i |=> reset_cause_o == `PMRS_CAUSE_RST && init_others_o)
      else $error("test-port reset not major");
   chk_pin_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (pin_reset_i && !test_reset_i && !wdog_reset_i) |=> !reset_cause_o[`PMRS_CAUSE_WDOG_BIT]
      && reset_cause_o[`PMRS_CAUSE_POR_BIT] == $past(s_q.por_flag))
      else $error("pin reset cause wrong");
   chk_cause_ro: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cause_wr_i && !any_reset) |=> reset_cause_o[`PMRS_CAUSE_WDOG_BIT] == $past(s_q.wdog_flag)
      && reset_cause_o[`PMRS_CAUSE_POR_BIT] == $past(cause_por_wdata_i))
      else $error("cause write wrong");
   chk_mask_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (ckmask_wr_i && !any_reset)
      |=> hard_sleep_o || periph_clk_en_o == (~$past(ckmask_wdata_i) & `PMRS_CKMASK_VALID))
      else $error("mask polarity wrong");
   // covers of the main scenarios
   cov_doze: cover property (@(posedge clk_i) disable iff (!reset_n_i) light_doze_mode_o);
   cov_idle_wake: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      idle_mode_o ##1 !idle_mode_o);
   cov_hard_minor: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      hard_sleep_o ##1 engine_min_reset_o);
   cov_wdog: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      wdog_reset_i ##1 reset_cause_o[`PMRS_CAUSE_WDOG_BIT]);
   cov_holdoff_end: cover property (@(posedge clk_i) disable iff (!reset_n_i)
      others_holdoff_o ##1 !others_holdoff_o);
endmodule

// *** core/pmrs_defs.svh ***
`ifndef PMRS_DEFS_SVH
`define PMRS_DEFS_SVH
// ----------------------------------------
// context count and master context number
// ----------------------------------------
`define PMRS_NCTX 5
`define PMRS_MASTER 3'h0
// ----------------------------------------
// master and other context initial values
// ----------------------------------------
`define PMRS_SR_INIT 16'h2700
`define PMRS_VBR_INIT 32'h0000_0000
`define PMRS_CTRL_MASTER 16'h1F02
`define PMRS_CTRL_OTHER 16'h1800
// ----------------------------------------
// reset-cause register layout
// ----------------------------------------
`define PMRS_CAUSE_RST 32'h0000_0001
`define PMRS_CAUSE_POR_BIT 0
`define PMRS_CAUSE_WDOG_BIT 1
// ----------------------------------------
// peripheral clock mask, inverted polarity
// ----------------------------------------
`define PMRS_CKMASK_RST 14'h3F0F
`define PMRS_CKMASK_VALID 14'h3F0F
`endif

// *** core/pmrs_pkg.sv ***
package pmrs_pkg;
   // power mode, one-hot
   typedef enum logic [3:0] {
      PMRS_RUN = 4'h1,
      PMRS_DOZE = 4'h2,
      PMRS_IDLE = 4'h4,
      PMRS_HARD = 4'h8
   } pmrs_mode_t;
   // kind of initialisation applied
   typedef enum logic [1:0] {
      PMRS_INIT_NONE = 2'h0,
      PMRS_INIT_MAJOR = 2'h1,
      PMRS_INIT_MINOR = 2'h2
   } pmrs_init_t;
   typedef struct packed {
      pmrs_mode_t mode;
      logic [4:0] ready;
      logic [4:0] halted;
      logic por_flag;
      logic wdog_flag;
      logic [13:0] ckmask;
      logic holdoff;
      logic [15:0] master_sr;
      pmrs_init_t init;
   } pmrs_state_t;
endpackage

// *** dv/pmrs_exec_model.sv ***
`timescale 1ns/1ps
module pmrs_exec_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // request from the bench
   input wire logic req_i,
   input wire logic [1:0] kind_i,
   input wire logic [2:0] ctx_i,
   input wire logic qual_i,
   input wire logic [15:0] operand_i,
   // toward the sequencer
   output logic instr_valid_o,
   output logic [2:0] instr_ctx_o,
   output logic sleep_o,
   output logic stop_o,
   output logic deep_o,
   output logic [15:0] operand_o,
   output logic irq_valid_o,
   output logic [2:0] irq_ctx_o,
   output logic irq_qual_o
);
   // one-cycle retire or interrupt; fields keep moving between requests
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         instr_valid_o <= 1'b0;
         sleep_o <= 1'b0;
         stop_o <= 1'b0;
         deep_o <= 1'b0;
         irq_valid_o <= 1'b0;
         irq_qual_o <= 1'b0;
         instr_ctx_o <= 3'h0;
         irq_ctx_o <= 3'h0;
         operand_o <= 16'h0000;
      end else begin
         instr_valid_o <= req_i && (kind_i != 2'h3);
         sleep_o <= req_i && (kind_i == 2'h0);
         stop_o <= req_i && (kind_i == 2'h1);
         deep_o <= req_i && (kind_i == 2'h2);
         irq_valid_o <= req_i && (kind_i == 2'h3);
         irq_qual_o <= req_i ? qual_i : ~irq_qual_o;
         instr_ctx_o <= req_i ? ctx_i : instr_ctx_o + 3'h1;
         irq_ctx_o <= req_i ? ctx_i : irq_ctx_o + 3'h1;
         operand_o <= req_i ? operand_i : ~operand_o;
      end
   end
endmodule

// *** dv/test_power_mode_reset_sequencer.sv ***
`timescale 1ns/1ps
module test_power_mode_reset_sequencer;
   // one table row: request, then expected outputs
   typedef struct packed {
      logic [1:0] kind;
      logic [2:0] ctx;
      logic qual;
      logic [15:0] op;
      logic [6:0] mode;
      logic [4:0] ready;
      logic [15:0] status;
      logic [13:0] per;
   } pmrs_row_t;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic pin_reset_i = 1'b0, test_reset_i = 1'b0, wdog_reset_i = 1'b0;
   logic cause_wr_i = 1'b0, cause_por_wdata_i = 1'b1, ckmask_wr_i = 1'b0;
   logic [13:0] ckmask_wdata_i = 14'h0000;
   logic req = 1'b0, req_qual = 1'b0;
   logic [1:0] req_kind = 2'h0;
   logic [2:0] req_ctx = 3'h0;
   logic [15:0] req_op = 16'h0000;
   logic instr_valid_i, sleep_instr_i, stop_instr_i, deep_halt_instr_i, irq_valid_i;
   logic irq_qualified_i;
   logic [2:0] instr_ctx_i, irq_ctx_i;
   logic [15:0] instr_operand_i, master_status_o;
   logic cpu_clk_en_o, master_clk_en_o, osc_en_o, scheduler_en_o, mem_access_en_o;
   logic light_doze_mode_o, idle_mode_o, hard_sleep_o, others_holdoff_o;
   logic init_master_o, init_others_o, engine_full_reset_o, engine_min_reset_o;
   logic [13:0] periph_clk_en_o, ckmask_o;
   logic [4:0] ctx_ready_o, ctx_halted_o;
   logic [31:0] reset_cause_o;
   logic [6:0] mw;
   logic [3:0] pulses;
   pmrs_row_t rows [10];
   int miscompares = 0;
   int total_checks = 0;
   // grouped views of the outputs
   assign mw = {light_doze_mode_o, idle_mode_o, hard_sleep_o, cpu_clk_en_o, master_clk_en_o,
                osc_en_o, scheduler_en_o};
   assign pulses = {init_master_o, init_others_o, engine_full_reset_o, engine_min_reset_o};
   pmrs_exec_model model (.clk_i, .reset_n_i, .req_i(req), .kind_i(req_kind), .ctx_i(req_ctx),
      .qual_i(req_qual), .operand_i(req_op), .instr_valid_o(instr_valid_i),
      .instr_ctx_o(instr_ctx_i), .sleep_o(sleep_instr_i), .stop_o(stop_instr_i),
      .deep_o(deep_halt_instr_i), .operand_o(instr_operand_i), .irq_valid_o(irq_valid_i),
      .irq_ctx_o(irq_ctx_i), .irq_qual_o(irq_qualified_i));
   pmrs_sequencer uut (.clk_i, .reset_n_i, .pin_reset_i, .test_reset_i, .wdog_reset_i,
      .instr_valid_i, .instr_ctx_i, .sleep_instr_i, .stop_instr_i, .deep_halt_instr_i,
      .instr_operand_i, .irq_valid_i, .irq_ctx_i, .irq_qualified_i, .cause_wr_i,
      .cause_por_wdata_i, .ckmask_wr_i, .ckmask_wdata_i, .cpu_clk_en_o, .master_clk_en_o,
      .osc_en_o, .scheduler_en_o, .mem_access_en_o, .periph_clk_en_o, .light_doze_mode_o,
      .idle_mode_o, .hard_sleep_o, .ctx_ready_o, .ctx_halted_o, .others_holdoff_o,
      .master_status_o, .init_master_o, .init_others_o, .engine_full_reset_o,
      .engine_min_reset_o, .reset_cause_o, .ckmask_o);
   // ----------------------------------------
   // clock, watchdog, tasks
   // ----------------------------------------
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      miscompares++;
      end_of_test();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // one request through the model, checked after the answer lands
   task automatic do_req(input pmrs_row_t r);
      @(posedge clk_i);
      req <= 1'b1;
      {req_kind, req_ctx, req_qual, req_op} <= {r.kind, r.ctx, r.qual, r.op};
      @(posedge clk_i);
      req <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // reset event pulse, then init pulses, cause, mask and master context
   task automatic do_rst(input logic [2:0] src, input logic [3:0] p, input logic [31:0] cause,
                         input logic [13:0] mask, input logic hold);
      @(posedge clk_i);
      {pin_reset_i, test_reset_i, wdog_reset_i} <= src;
      @(posedge clk_i);
      {pin_reset_i, test_reset_i, wdog_reset_i} <= 3'h0;
      @(negedge clk_i);
      chk(pulses, p);
      chk(reset_cause_o, cause);
      chk(ckmask_o, mask);
      chk(others_holdoff_o, hold);
      chk(mw, 7'h0F);
      chk({ctx_ready_o, ctx_halted_o, master_status_o}, {5'h01, 5'h1E, 16'h2700});
      @(negedge clk_i);
      chk(pulses, 4'h0);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rows = '{{2'h0, 3'h0, 1'b0, 16'h0000, 7'h4F, 5'h00, 16'h2700, 14'h000A},
               {2'h3, 3'h0, 1'b0, 16'h0000, 7'h4F, 5'h00, 16'h2700, 14'h000A},
               {2'h3, 3'h0, 1'b1, 16'h0000, 7'h0F, 5'h01, 16'h2700, 14'h000A},
               {2'h1, 3'h0, 1'b0, 16'h2104, 7'h27, 5'h00, 16'h2104, 14'h000A},
               {2'h3, 3'h0, 1'b1, 16'h0000, 7'h0F, 5'h01, 16'h2104, 14'h000A},
               {2'h1, 3'h1, 1'b0, 16'h2311, 7'h0F, 5'h01, 16'h2311, 14'h000A},
               {2'h2, 3'h2, 1'b0, 16'h2312, 7'h0F, 5'h01, 16'h2312, 14'h000A},
               {2'h3, 3'h1, 1'b1, 16'h0000, 7'h0F, 5'h01, 16'h2312, 14'h000A},
               {2'h2, 3'h0, 1'b0, 16'h2205, 7'h10, 5'h01, 16'h2205, 14'h0000},
               {2'h3, 3'h0, 1'b1, 16'h0000, 7'h10, 5'h01, 16'h2205, 14'h0000}};
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      chk(pulses, 4'hE);
      chk(reset_cause_o, 32'h0000_0001);
      chk({ckmask_o, periph_clk_en_o}, {14'h3F0F, 14'h0000});
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      {ckmask_wr_i, ckmask_wdata_i, cause_wr_i, cause_por_wdata_i} <= {1'b1, 14'h3FF5, 2'h2};
      @(posedge clk_i);
      {ckmask_wr_i, cause_wr_i} <= 2'h0;
      @(negedge clk_i);
      chk(pulses, 4'h0);
      chk({ckmask_o, periph_clk_en_o}, {14'h3F05, 14'h000A});
      chk(reset_cause_o, 32'h0000_0000);
      foreach (rows[i]) begin
         do_req(rows[i]);
         chk(mw, rows[i].mode);
         chk(mem_access_en_o, rows[i].mode[6:4] == 3'h0);
         chk({ctx_ready_o, master_status_o}, {rows[i].ready, rows[i].status});
         chk(periph_clk_en_o, rows[i].per);
      end
      do_rst(3'h4, 4'h9, 32'h0, 14'h3F05, 1'b1);
      do_req(rows[0]);
      chk(others_holdoff_o, 1'b0);
      do_rst(3'h1, 4'hE, 32'h2, 14'h3F0F, 1'b0);
      do_rst(3'h4, 4'h9, 32'h0, 14'h3F0F, 1'b1);
      do_rst(3'h2, 4'hE, 32'h1, 14'h3F0F, 1'b0);
      do_rst(3'h4, 4'hE, 32'h1, 14'h3F0F, 1'b0);
      end_of_test();
   end
endmodule
